// ===== logic/lin_sync_port.sv
// serial port with break send/detect, auto-wake and synchronous master transmit
// assumes sys_clk at 125 MHz; data_pin_in is asynchronous and synchronised here
module lin_sync_port
  import lin_sync_pkg::*;
#(
  parameter int CHAR_BITS = 8
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic data_pin_in,
  output logic data_pin_out,
  output logic data_pin_oe,
  output logic clock_pin_out,
  output logic clock_pin_oe,
  output logic transmit_buffer_empty_flag,
  output logic receive_flag
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [CW-1:0] bit_cycles(input logic [15:0] div, input logic hs,
                                               input logic wide);
    logic [CW-1:0] base;
    logic [4:0] sh;
    base = {8'h00, (wide ? div : {8'h00, div[7:0]})} + 24'h000001;
    sh = (hs && wide) ? SHIFT_FAST : ((hs || wide) ? SHIFT_MID : SHIFT_SLOW);
    bit_cycles = base << sh;
  endfunction : bit_cycles

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic clock_source_master_r, transmit_enable_r, sync_r, sbrk_r, baud_high_speed_r;
  logic serial_port_enable_r, single_receive_enable_r, continuous_receive_enable_r, framing_error_r;
  logic pol_r, wide_r, wue_r, abd_r;
  logic [7:0] div_lo_r, div_hi_r, rxd_r;
  logic [7:0] buf_r;
  logic buf_full_r, buf_brk_r, rflag_r;
  tx_state_t tx_st_r;
  rx_state_t rx_st_r;
  logic [CW-1:0] tx_cnt_r, rx_cnt_r;
  logic [3:0] tx_idx_r, rx_idx_r;
  logic [7:0] tx_sh_r, rx_sh_r;
  logic brk_act_r;
  logic din_s1_r, din_s2_r, din_s3_r;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  port_cfg_t cfg;
  wire [CW-1:0] len = bit_cycles({div_hi_r, div_lo_r}, baud_high_speed_r, wide_r);
  wire [CW-1:0] half = len >> 1;
  wire wr_tx_ctrl = wr_en && addr == ADDR_TX_CTRL;
  wire wr_rx_ctrl = wr_en && addr == ADDR_RX_CTRL;
  wire wr_baud = wr_en && addr == ADDR_BAUD_CTRL;
  wire wr_data = wr_en && addr == ADDR_TX_DATA;
  wire rd_rxdata = rd_en && addr == ADDR_RX_DATA;

  assign cfg = '{serial_port_enable: serial_port_enable_r, sync: sync_r, clock_source_master: clock_source_master_r, transmit_enable: transmit_enable_r,
                 rxsel: single_receive_enable_r | continuous_receive_enable_r, pol: pol_r};

  wire sync_master = cfg.serial_port_enable && cfg.sync && cfg.clock_source_master;
  wire tx_allowed = cfg.serial_port_enable && cfg.transmit_enable && !(cfg.sync && cfg.rxsel);
  wire tx_end = tx_st_r != TX_IDLE && tx_cnt_r == '0;
  wire last_bit = tx_st_r == TX_STOP || (tx_st_r == TX_SBIT && tx_idx_r == CHAR_BITS[3:0] - 4'h1);
  wire char_done = tx_end && last_bit;
  // load only from idle or at the very end of the last bit: no gap, no overlap
  wire tx_load = buf_full_r && tx_allowed && (tx_st_r == TX_IDLE || char_done);
  wire data_last = tx_idx_r == (brk_act_r ? BREAK_ZEROS : DATA_BITS) - 4'h1;
  wire brk_done = char_done && brk_act_r;
  // a break marks only the first write; later writes are ordinary bytes
  wire new_brk = sbrk_r && !brk_act_r && !(buf_full_r && buf_brk_r);
  wire accept = wr_data && !buf_full_r && cfg.transmit_enable;

  wire txd = (tx_st_r == TX_DATA || tx_st_r == TX_SBIT) ? tx_sh_r[0] : (tx_st_r != TX_START);
  // leading edge at bit start, trailing edge at mid bit
  wire sclk = (tx_st_r == TX_SBIT && tx_cnt_r >= half) ? !cfg.pol : cfg.pol;

  wire din_fall = din_s3_r && !din_s2_r;
  wire din_rise = !din_s3_r && din_s2_r;
  wire rx_allowed = cfg.serial_port_enable && continuous_receive_enable_r && !cfg.sync && !wue_r;
  wire rx_end = rx_st_r != RX_IDLE && rx_cnt_r == '0;
  wire rx_got = rx_end && rx_st_r == RX_STOP;
  wire wake_evt = wue_r && cfg.serial_port_enable && din_fall;
  wire rflag_set = rx_got || wake_evt;

  tx_state_t tx_after;
  assign tx_after = (tx_st_r == TX_START) ? TX_DATA :
                    (tx_st_r == TX_DATA && data_last) ? TX_STOP :
                    (tx_st_r == TX_DATA || tx_st_r == TX_SBIT) ? tx_st_r : TX_IDLE;

  // ----------------------------------------------------------------
  // synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    din_s1_r <= data_pin_in;
    din_s2_r <= din_s1_r;
    din_s3_r <= din_s2_r;
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      {clock_source_master_r, transmit_enable_r, sync_r, baud_high_speed_r} <= 4'h0;
      {serial_port_enable_r, single_receive_enable_r, continuous_receive_enable_r} <= 3'h0;
      {pol_r, wide_r, abd_r} <= 3'h0;
      div_lo_r <= RESET_DIV[7:0];
      div_hi_r <= RESET_DIV[15:8];
    end else begin
      if (wr_tx_ctrl) begin
        clock_source_master_r <= wdata[TXC_CLOCK_SOURCE_MASTER];
        transmit_enable_r <= wdata[TXC_TRANSMIT_ENABLE];
        sync_r <= wdata[TXC_SYNC];
        baud_high_speed_r <= wdata[TXC_BAUD_HIGH_SPEED];
      end
      if (wr_rx_ctrl) begin
        serial_port_enable_r <= wdata[RXC_SERIAL_PORT_ENABLE];
        single_receive_enable_r <= wdata[RXC_SINGLE_RECEIVE_ENABLE];
        continuous_receive_enable_r <= wdata[RXC_CONTINUOUS_RECEIVE_ENABLE];
      end
      if (wr_baud) begin
        pol_r <= wdata[BC_POL];
        wide_r <= wdata[BC_WIDE];
        abd_r <= wdata[BC_ABD];
      end
      if (wr_en && addr == ADDR_DIV_LO) div_lo_r <= wdata;
      if (wr_en && addr == ADDR_DIV_HI) div_hi_r <= wdata;
    end
  end

  // self-clearing bits: a software write in the same cycle wins
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sbrk_r <= 1'b0;
      wue_r <= 1'b0;
    end else begin
      if (wr_tx_ctrl) sbrk_r <= wdata[TXC_SBRK];
      else if (brk_done) sbrk_r <= 1'b0;
      // plain edge on the sampled line, no dependence on any other clock
      if (wr_baud) wue_r <= wdata[BC_WAKE];
      else if (wue_r && din_rise) wue_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // transmit buffer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      buf_r <= RESET_BYTE;
      buf_full_r <= 1'b0;
      buf_brk_r <= 1'b0;
    end else if (accept) begin
      buf_r <= wdata;
      buf_full_r <= 1'b1;
      buf_brk_r <= new_brk;
    end else if (tx_load) begin
      buf_full_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // transmit shifter
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset || !tx_allowed) begin
      tx_st_r <= TX_IDLE;
      tx_cnt_r <= '0;
      tx_idx_r <= 4'h0;
      tx_sh_r <= RESET_BYTE;
      brk_act_r <= 1'b0;
    end else if (tx_load) begin
      tx_st_r <= cfg.sync ? TX_SBIT : TX_START;
      tx_cnt_r <= len - 24'h000001;
      tx_idx_r <= 4'h0;
      tx_sh_r <= buf_brk_r ? BREAK_FILL : buf_r;
      brk_act_r <= buf_brk_r;
    end else if (tx_end) begin
      tx_st_r <= char_done ? TX_IDLE : tx_after;
      tx_cnt_r <= len - 24'h000001;
      if (tx_st_r == TX_DATA || tx_st_r == TX_SBIT) begin
        tx_idx_r <= tx_idx_r + 4'h1;
        tx_sh_r <= {1'b0, tx_sh_r[7:1]};
      end
      if (char_done) brk_act_r <= 1'b0;
    end else if (tx_st_r != TX_IDLE) begin
      tx_cnt_r <= tx_cnt_r - 24'h000001;
    end
  end

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset || !rx_allowed) begin
      rx_st_r <= RX_IDLE;
      rx_cnt_r <= '0;
      rx_idx_r <= 4'h0;
      rx_sh_r <= RESET_BYTE;
    end else begin
      case (rx_st_r)
        RX_IDLE: begin
          if (din_fall) begin
            rx_st_r <= RX_START;
            rx_cnt_r <= half;
          end
        end
        RX_START: begin
          if (rx_end) begin
            rx_st_r <= din_s2_r ? RX_IDLE : RX_DATA;
            rx_cnt_r <= len - 24'h000001;
            rx_idx_r <= 4'h0;
          end else rx_cnt_r <= rx_cnt_r - 24'h000001;
        end
        RX_DATA: begin
          if (rx_end) begin
            rx_sh_r <= {din_s2_r, rx_sh_r[7:1]};
            rx_idx_r <= rx_idx_r + 4'h1;
            rx_cnt_r <= len - 24'h000001;
            if (rx_idx_r == DATA_BITS - 4'h1) rx_st_r <= RX_STOP;
          end else rx_cnt_r <= rx_cnt_r - 24'h000001;
        end
        RX_STOP: begin
          if (rx_end) rx_st_r <= RX_IDLE;
          else rx_cnt_r <= rx_cnt_r - 24'h000001;
        end
        default: rx_st_r <= RX_IDLE;
      endcase
    end
  end

  // received character and flags; a new event beats a clearing read
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rxd_r <= RESET_BYTE;
      framing_error_r <= 1'b0;
      rflag_r <= 1'b0;
    end else begin
      if (rx_got) begin
        rxd_r <= rx_sh_r;
        framing_error_r <= !din_s2_r;
      end
      if (rflag_set) rflag_r <= 1'b1;
      else if (rd_rxdata) rflag_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // pins and read port (all registered)
  // ----------------------------------------------------------------
  wire sync_data_drive = sync_master && cfg.transmit_enable && !cfg.rxsel;
  wire [7:0] tx_ctrl_rd = (8'(clock_source_master_r) << TXC_CLOCK_SOURCE_MASTER) | (8'(transmit_enable_r) << TXC_TRANSMIT_ENABLE) |
                          (8'(sync_r) << TXC_SYNC) | (8'(sbrk_r) << TXC_SBRK) |
                          (8'(baud_high_speed_r) << TXC_BAUD_HIGH_SPEED) |
                          (8'(tx_st_r == TX_IDLE && !tx_load) << TXC_SHIFT_REGISTER_EMPTY);
  wire [7:0] rx_ctrl_rd = (8'(serial_port_enable_r) << RXC_SERIAL_PORT_ENABLE) | (8'(single_receive_enable_r) << RXC_SINGLE_RECEIVE_ENABLE) |
                          (8'(continuous_receive_enable_r) << RXC_CONTINUOUS_RECEIVE_ENABLE) | (8'(framing_error_r) << RXC_FRAMING_ERROR);
  wire [7:0] baud_rd = (8'(pol_r) << BC_POL) | (8'(wide_r) << BC_WIDE) |
                       (8'(wue_r) << BC_WAKE) | (8'(abd_r) << BC_ABD);
  wire [7:0] flags_rd = (8'(!buf_full_r) << FL_TXBE) | (8'(rflag_r) << FL_RXF);
  wire [7:0] rd_mux = (addr == ADDR_TX_CTRL) ? tx_ctrl_rd :
                      (addr == ADDR_RX_CTRL) ? rx_ctrl_rd :
                      (addr == ADDR_BAUD_CTRL) ? baud_rd :
                      (addr == ADDR_DIV_LO) ? div_lo_r :
                      (addr == ADDR_DIV_HI) ? div_hi_r :
                      (addr == ADDR_RX_DATA) ? rxd_r :
                      (addr == ADDR_FLAGS) ? flags_rd : RESET_BYTE;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdata <= RESET_BYTE;
      data_pin_out <= 1'b1;
      data_pin_oe <= 1'b0;
      clock_pin_out <= 1'b1;
      clock_pin_oe <= 1'b0;
      transmit_buffer_empty_flag <= 1'b1;
      receive_flag <= 1'b0;
    end else begin
      rdata <= rd_en ? rd_mux : RESET_BYTE;
      data_pin_out <= txd;
      data_pin_oe <= sync_data_drive;
      // async mode the clock pin carries the serial line
      clock_pin_out <= cfg.sync ? sclk : txd;
      clock_pin_oe <= cfg.sync ? sync_master : (cfg.serial_port_enable && cfg.transmit_enable);
      transmit_buffer_empty_flag <= !buf_full_r;
      receive_flag <= rflag_r;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_wake_rx_idle: assert property (wue_r |-> rx_st_r == RX_IDLE)
    else $error("receiver left idle while auto-wake set");
  a_wake_clear_edge: assert property (wue_r && din_rise && !wr_baud |=> !wue_r)
    else $error("auto-wake not cleared on rising line");
  a_break_zero_line: assert property (brk_act_r && tx_st_r == TX_DATA |-> !txd)
    else $error("break data bit not zero");
  a_break_length: assert property (brk_act_r && tx_st_r == TX_DATA && tx_end &&
                                   tx_idx_r == BREAK_ZEROS - 4'h1 |=> tx_st_r == TX_STOP)
    else $error("break zero count wrong");
  a_break_discard: assert property (tx_load && buf_brk_r |=> tx_sh_r == BREAK_FILL)
    else $error("break byte not discarded");
  a_send_break_request_clear: assert property ($fell(sbrk_r) |-> $past(brk_done) || $past(wr_tx_ctrl))
    else $error("send-break cleared at wrong time");
  a_queue_follows: assert property (brk_done && buf_full_r && tx_allowed |=>
                                    tx_st_r == TX_START && !brk_act_r)
    else $error("queued byte did not follow break");
  a_shift_register_empty_busy: assert property (tx_st_r != TX_IDLE |-> !tx_ctrl_rd[TXC_SHIFT_REGISTER_EMPTY])
    else $error("shift-empty shown while busy");
  a_buf_empty: assert property (tx_load && !accept |=> ##1 transmit_buffer_empty_flag)
    else $error("buffer-empty flag not raised");
  a_rx_break: assert property (rx_got && rx_sh_r == BREAK_FILL && !din_s2_r |=>
                               rflag_r && framing_error_r && rxd_r == BREAK_FILL)
    else $error("break not reported");
  a_wake_flag: assert property (wake_evt |=> rflag_r)
    else $error("wake event not flagged");
  a_sync_no_frame: assert property (sync_r |-> tx_st_r != TX_START && tx_st_r != TX_STOP)
    else $error("start or stop bit in sync mode");
  a_sync_clock_idle: assert property (sync_master && tx_st_r == TX_IDLE |=>
                                      clock_pin_out == $past(pol_r) && clock_pin_oe)
    else $error("sync clock idle level wrong");
  a_data_stable_half: assert property (tx_st_r == TX_SBIT && tx_cnt_r == half && !tx_end |=>
                                       $stable(txd))
    else $error("data moved at trailing edge");
  a_rx_half_duplex: assert property (sync_r && (single_receive_enable_r || continuous_receive_enable_r) |-> tx_st_r == TX_IDLE)
    else $error("transmit while receive selected");

  c_break_sent: cover property (brk_done);
  c_break_then_sync: cover property (brk_done ##1 tx_st_r == TX_START);
  c_sync_char: cover property (tx_st_r == TX_SBIT && char_done);
  c_wake_seq: cover property (wake_evt ##[1:1000] (wue_r && din_rise));

endmodule : lin_sync_port

// ===== logic/lin_sync_pkg.sv
// shared constants and types for the break/sync-capable serial port
// assumes a single 125 MHz system clock and an 8-bit register port
package lin_sync_pkg;

  // ----------------------------------------------------------------
  // register map (3-bit word address, 8-bit data)
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_TX_CTRL = 3'h0;
  localparam logic [2:0] ADDR_RX_CTRL = 3'h1;
  localparam logic [2:0] ADDR_BAUD_CTRL = 3'h2;
  localparam logic [2:0] ADDR_DIV_LO = 3'h3;
  localparam logic [2:0] ADDR_DIV_HI = 3'h4;
  localparam logic [2:0] ADDR_TX_DATA = 3'h5;
  localparam logic [2:0] ADDR_RX_DATA = 3'h6;
  localparam logic [2:0] ADDR_FLAGS = 3'h7;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int TXC_CLOCK_SOURCE_MASTER = 7;
  localparam int TXC_TRANSMIT_ENABLE = 5;
  localparam int TXC_SYNC = 4;
  localparam int TXC_SBRK = 3;
  localparam int TXC_BAUD_HIGH_SPEED = 2;
  localparam int TXC_SHIFT_REGISTER_EMPTY = 1;
  localparam int RXC_SERIAL_PORT_ENABLE = 7;
  localparam int RXC_SINGLE_RECEIVE_ENABLE = 5;
  localparam int RXC_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int RXC_FRAMING_ERROR = 2;
  localparam int BC_POL = 4;
  localparam int BC_WIDE = 3;
  localparam int BC_WAKE = 1;
  localparam int BC_ABD = 0;
  localparam int FL_TXBE = 0;
  localparam int FL_RXF = 1;

  // ----------------------------------------------------------------
  // reset values and character shapes
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_DIV = 16'h0000;
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [3:0] BREAK_ZEROS = 4'hC;
  localparam logic [7:0] BREAK_FILL = 8'h00;
  localparam logic [4:0] SHIFT_SLOW = 5'h06;
  localparam logic [4:0] SHIFT_MID = 5'h04;
  localparam logic [4:0] SHIFT_FAST = 5'h02;
  localparam int CW = 24;

  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001,
    TX_START = 5'b00010,
    TX_DATA = 5'b00100,
    TX_STOP = 5'b01000,
    TX_SBIT = 5'b10000
  } tx_state_t;

  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA = 4'b0100,
    RX_STOP = 4'b1000
  } rx_state_t;

  // configuration bundle decoded from the control registers
  typedef struct packed {
    logic serial_port_enable;
    logic sync;
    logic clock_source_master;
    logic transmit_enable;
    logic rxsel;
    logic pol;
  } port_cfg_t;

endpackage : lin_sync_pkg

// ===== bench/lin_node_model.sv
// far-side model: a LIN node on the receive line and a clocked slave on the sync pins
// assumes the bench resolves the shared data line and pulses cap_clr before each capture
module lin_node_model (
  input wire logic sys_clk,
  input wire logic clk_line,
  input wire logic data_line,
  input wire logic pol,
  input wire logic cap_clr,
  output logic line_out,
  output logic [15:0] cap_bits,
  output int cap_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // slave capture
  // ----------------------------------------------------------------
  logic clk_q;
  initial line_out = 1'b1;
  // sample where the clock returns to idle; data is only trusted there
  always @(posedge sys_clk) begin
    clk_q <= clk_line;
    if (cap_clr) begin
      cap_cnt <= 0;
      cap_bits <= 16'h0000;
    end else if (clk_q !== pol && clk_line === pol) begin
      cap_bits <= {data_line, cap_bits[15:1]};
      cap_cnt <= cap_cnt + 1;
    end
  end
  // ----------------------------------------------------------------
  // node transmit, own 125 ns bit clock, unrelated in phase
  // ----------------------------------------------------------------
  // the node drives the line high again once its last bit is sent
  task automatic send(input logic [15:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      line_out = bits[i];
      #125;
    end
    line_out = 1'b1;
  endtask : send
endmodule : lin_node_model

// ===== bench/tb_top.sv
// self-checking bench for the break/sync serial port
// assumes lin_sync_pkg register map; bit time set to 16 clocks (div 3, high speed, wide)
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import lin_sync_pkg::*;
  localparam int L = 16;
  logic sys_clk, reset, wr_en, rd_en, cap_clr, pol_r;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, b0, b1;
  logic data_pin_in, data_pin_out, data_pin_oe, clock_pin_out, clock_pin_oe, txbe, rxf;
  logic node_line;
  logic [15:0] cap_bits, f0, f1;
  logic [31:0] seed;
  int cap_cnt, error_cnt, comparisons, cyc;
  // the data line is shared: the port wins only while it drives
  assign data_pin_in = data_pin_oe ? data_pin_out : node_line;
  lin_sync_port u_lin_sync_port (.sys_clk(sys_clk), .reset(reset), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .data_pin_in(data_pin_in),
    .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe), .clock_pin_out(clock_pin_out),
    .clock_pin_oe(clock_pin_oe), .transmit_buffer_empty_flag(txbe), .receive_flag(rxf));
  lin_node_model u_lin_node_model (.sys_clk(sys_clk), .clk_line(clock_pin_out),
    .data_line(data_pin_out), .pol(pol_r), .cap_clr(cap_clr), .line_out(node_line),
    .cap_bits(cap_bits), .cap_cnt(cap_cnt));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  function automatic logic [15:0] async_frame(input logic [7:0] d);
    return {6'h00, 1'b1, d, 1'b0};
  endfunction : async_frame
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  // one idle cycle after each write so the strobe is never re-raised in the same step
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
    @(posedge sys_clk);
  endtask : wr
  task automatic rdchk(input string what, input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 d = rdata;
    @(posedge sys_clk);
    chk(what, {8'h00, e}, {8'h00, d});
  endtask : rdchk
  // async frame off the transmit pin, sampled mid-bit
  task automatic grab(input int n, output logic [15:0] b);
    b = 16'h0000;
    repeat (3000) if (clock_pin_out !== 1'b0) begin
      @(posedge sys_clk);
      #1;
    end
    repeat (L / 2) @(posedge sys_clk);
    // no trailing wait: a frame that follows with no gap is found by its own start edge
    for (int i = 0; i < n; i++) begin
      if (i > 0) repeat (L) @(posedge sys_clk);
      #1 b[i] = clock_pin_out;
    end
  endtask : grab
  task automatic wait_txbe();
    repeat (3000) if (txbe !== 1'b1) @(posedge sys_clk);
  endtask : wait_txbe
  task automatic wait_rxf();
    repeat (3000) if (rxf !== 1'b1) @(posedge sys_clk);
  endtask : wait_rxf
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------------------------------
  // clock, timeout
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // whole run needs well under 10k cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      $display("FAIL timeout expected finish seen hang");
      tally_and_finish();
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {wr_en, rd_en, cap_clr, pol_r} = 4'h0;
    reset = 1'b1;
    addr = 3'h0;
    wdata = 8'h00;
    seed = 32'h2674F147;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    #1 chk("idle pins", 16'h0009, {12'h000, txbe, rxf, clock_pin_oe, data_pin_out});
    rdchk("tx ctrl reset", ADDR_TX_CTRL, 8'h02);
    rdchk("flags reset", ADDR_FLAGS, 8'h01);
    rdchk("tx data reads zero", ADDR_TX_DATA, 8'h00);
    $display("test reset done");
    // break then sync header, host side as a LIN master would do it
    wr(ADDR_DIV_LO, 8'h03);
    wr(ADDR_BAUD_CTRL, 8'h08);
    wr(ADDR_RX_CTRL, 8'h90);
    wr(ADDR_TX_CTRL, 8'h2C);
    seed = xs(seed);
    fork
      begin
        grab(14, f0);
        grab(10, f1);
      end
      begin
        wr(ADDR_TX_DATA, seed[7:0] | 8'h01);
        rdchk("break busy", ADDR_TX_CTRL, 8'h2C);
        wait_txbe();
        wr(ADDR_TX_DATA, 8'h55);
      end
    join
    chk("break shape", 16'h2000, f0);
    chk("sync after break", async_frame(8'h55), f1);
    repeat (2 * L) @(posedge sys_clk);
    rdchk("break flag cleared", ADDR_TX_CTRL, 8'h26);
    $display("test break send done");
    // a break arriving from the node, then an ordinary byte
    u_lin_node_model.send(16'h2000, 14);
    wait_rxf();
    rdchk("break framing", ADDR_RX_CTRL, 8'h94);
    rdchk("break data", ADDR_RX_DATA, 8'h00);
    seed = xs(seed);
    u_lin_node_model.send(async_frame(seed[7:0]), 10);
    wait_rxf();
    rdchk("byte framing", ADDR_RX_CTRL, 8'h90);
    rdchk("byte data", ADDR_RX_DATA, seed[7:0]);
    #1 chk("flag cleared by read", 16'h0000, {15'h0000, rxf});
    $display("test break receive done");
    // auto-wake across a long low
    wr(ADDR_BAUD_CTRL, 8'h0B);
    fork
      u_lin_node_model.send(16'h2000, 14);
      begin
        wait_rxf();
        chk("wake flag", 16'h0001, {15'h0000, rxf});
        rdchk("wake held while low", ADDR_BAUD_CTRL, 8'h0B);
        rdchk("wake data discarded", ADDR_RX_DATA, seed[7:0]);
      end
    join
    repeat (10) @(posedge sys_clk);
    rdchk("wake cleared on rise", ADDR_BAUD_CTRL, 8'h09);
    chk("no char while waking", 16'h0000, {15'h0000, rxf});
    seed = xs(seed);
    u_lin_node_model.send(async_frame(seed[7:0]), 10);
    wait_rxf();
    rdchk("byte after wake", ADDR_RX_DATA, seed[7:0]);
    $display("test auto wake done");
    // synchronous master transmit, both clock polarities
    for (int p = 0; p < 2; p++) begin
      pol_r = p[0];
      wr(ADDR_RX_CTRL, 8'h80);
      wr(ADDR_BAUD_CTRL, {3'b000, p[0], 4'h8});
      wr(ADDR_TX_CTRL, 8'hB4);
      cap_clr <= 1'b1;
      @(posedge sys_clk);
      cap_clr <= 1'b0;
      repeat (4) @(posedge sys_clk);
      #1 chk("sync drivers", {14'h0000, 1'b1, p[0]}, {14'h0000, data_pin_oe & clock_pin_oe,
        clock_pin_out});
      seed = xs(seed);
      b0 = seed[7:0];
      b1 = seed[15:8];
      wr(ADDR_TX_DATA, b0);
      wait_txbe();
      wr(ADDR_TX_DATA, b1);
      repeat (3000) if (cap_cnt < 16) @(posedge sys_clk);
      repeat (2 * L) @(posedge sys_clk);
      chk("sync clock count", 16'd16, 16'(cap_cnt));
      chk("sync data", {b1, b0}, cap_bits);
      #1 chk("sync idle level", {15'h0000, p[0]}, {15'h0000, clock_pin_out});
    end
    wr(ADDR_RX_CTRL, 8'hA0);
    repeat (2) @(posedge sys_clk);
    #1 chk("receive select", 16'h0001, {14'h0000, data_pin_oe, clock_pin_oe});
    @(posedge sys_clk);
    $display("test sync master done");
    tally_and_finish();
  end
endmodule : tb_top
